/* File: core/transmit_sync_clocking.v */
// Transmit clock selection and frame sync for one framer port
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "tx_sync_regs.vh"

// Functional notes
// RULE_01: Bus mode needs line clock synchronous
// RULE_02: Line clock required unless sourced internally
// RULE_03: System clock runs at listed rates
// RULE_04: System clock used only with store
// RULE_05: Bus mode system clock 4/8/16 MHz
// RULE_06: Compat mode uses port-one system clock
// RULE_07: Status pin shows selected loss/freeze
// RULE_08: Status pin active only in compat
// RULE_09: Sync input pulse sets frame boundary
// RULE_10: Sync output pulses frame or multiframe
// RULE_11: T1 double-wide pulse at signaling frames
// RULE_12: Line sync timed to line clock
// RULE_13: Store enabled: sync uses system clock
// RULE_14: Store output: pulse per system frame
// RULE_15: Serial data sampled on falling edge
// RULE_16: Sync settings apply at frame boundary
module transmit_sync_clocking #(
  parameter PORT_INDEX = 2,
  parameter SYS_CLKS_PER_FRAME = 256
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] address,
  input wire [31:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [31:0] read_data,
  output reg irq,
  input wire transmit_line_clock,
  input wire recovered_rx_clock,
  input wire transmit_system_clock,
  input wire port1_system_clock,
  input wire transmit_serial_data,
  input wire analog_loss_flag,
  input wire framer_signal_loss_flag,
  input wire rx_signaling_freeze_flag,
  input wire sync_io_in,
  output reg sync_io_out,
  output reg sync_io_oe_n,
  output reg status_pin_out,
  output reg status_pin_oe_n,
  output reg backplane_clock_out,
  output reg serial_bit,
  output reg serial_bit_valid
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [`EV_WIDTH-1:0] status;
  reg [`EV_WIDTH-1:0] mask;
  reg act_out;
  reg act_mf;
  reg act_dw;
  reg clk_loss;
  reg [11:0] loss_cnt;
  reg sys_pulse;

  wire es_en = ctrl[`CTRL_ES_EN];
  wire t1 = ctrl[`CTRL_T1];
  wire clk_int = ctrl[`CTRL_CLK_INT];
  wire compat = ctrl[`CTRL_COMPAT];
  wire [1:0] stsel = ctrl[`CTRL_STSEL_HI:`CTRL_STSEL_LO];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire transmit_line_clock_rise;
  wire transmit_line_clock_fall;
  wire rclk_rise;
  wire rclk_fall;
  wire own_sys_lvl;
  wire own_sys_rise;
  wire own_sys_fall;
  wire p1_sys_lvl;
  wire p1_sys_rise;
  wire p1_sys_fall;
  wire data_lvl;
  wire sync_lvl;
  wire sync_rise;

  pin_sync u_transmit_line_clock (
    .clk(clk),
    .rstn(rstn),
    .pin(transmit_line_clock),
    .level(),
    .rise(transmit_line_clock_rise),
    .fall(transmit_line_clock_fall)
  );
  pin_sync u_rclk (
    .clk(clk),
    .rstn(rstn),
    .pin(recovered_rx_clock),
    .level(),
    .rise(rclk_rise),
    .fall(rclk_fall)
  );
  pin_sync u_own_sys (
    .clk(clk),
    .rstn(rstn),
    .pin(transmit_system_clock),
    .level(own_sys_lvl),
    .rise(own_sys_rise),
    .fall(own_sys_fall)
  );
  pin_sync u_p1_sys (
    .clk(clk),
    .rstn(rstn),
    .pin(port1_system_clock),
    .level(p1_sys_lvl),
    .rise(p1_sys_rise),
    .fall(p1_sys_fall)
  );
  pin_sync u_data (
    .clk(clk),
    .rstn(rstn),
    .pin(transmit_serial_data),
    .level(data_lvl),
    .rise(),
    .fall()
  );
  pin_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(sync_io_in),
    .level(sync_lvl),
    .rise(sync_rise),
    .fall()
  );

  // ----------------------------------------
  // Clock selection
  // ----------------------------------------
  // Line clock from pin, or recovered clock when sourced internally
  wire line_fall = clk_int ? rclk_fall : transmit_line_clock_fall; // RULE_02
  wire line_rise = clk_int ? rclk_rise : transmit_line_clock_rise; // RULE_02
  // Other ports' system clock pins are ignored in compat mode
  wire sys_lvl = compat ? p1_sys_lvl : own_sys_lvl; // RULE_06
  wire sys_rise_raw = compat ? p1_sys_rise : own_sys_rise; // RULE_06
  wire sys_fall_raw = compat ? p1_sys_fall : own_sys_fall; // RULE_06
  // System clock has no effect while the store is off
  wire sys_rise = es_en & sys_rise_raw; // RULE_04
  wire sys_fall = es_en & sys_fall_raw; // RULE_04
  // Serial data edge follows the store setting
  wire data_edge = es_en ? sys_fall : line_fall; // RULE_15

  // ----------------------------------------
  // Line-side frame counters
  // ----------------------------------------
  wire [7:0] bit_limit = t1 ? `T1_BIT_LIMIT : `E1_BIT_LIMIT;
  wire [4:0] frame_limit = t1 ? `T1_FRAME_LIMIT : `E1_FRAME_LIMIT;
  wire [7:0] bit_cnt;
  wire [4:0] frame_cnt;
  wire bit_wrap;
  wire frame_wrap;
  // Realign only while the pin is an input on the line side
  wire line_sync_in = ~es_en & ~act_out & line_fall & sync_lvl;
  wire sys_sync_in = ~act_out & sys_fall & sync_lvl;

  edge_counter #(
    .WIDTH(8)
  ) u_bits (
    .clk(clk),
    .rstn(rstn),
    .step(line_fall),
    .load(line_sync_in), // RULE_09
    .limit(bit_limit),
    .count(bit_cnt),
    .wrap(bit_wrap)
  );
  edge_counter #(
    .WIDTH(5)
  ) u_frames (
    .clk(clk),
    .rstn(rstn),
    .step(bit_wrap),
    .load(line_sync_in & act_mf), // RULE_09
    .limit(frame_limit),
    .count(frame_cnt),
    .wrap(frame_wrap)
  );

  // ----------------------------------------
  // System-side frame counter
  // ----------------------------------------
  localparam [31:0] SYS_LIMIT_FULL = SYS_CLKS_PER_FRAME - 1;
  localparam [11:0] SYS_LIMIT = SYS_LIMIT_FULL[11:0];
  wire [11:0] sys_cnt;
  wire sys_wrap;

  edge_counter #(
    .WIDTH(12)
  ) u_sys (
    .clk(clk),
    .rstn(rstn),
    .step(sys_rise),
    .load(sys_sync_in), // RULE_13
    .limit(SYS_LIMIT),
    .count(sys_cnt),
    .wrap(sys_wrap)
  );

  // ----------------------------------------
  // Active sync settings
  // ----------------------------------------
  // Changing direction mid-frame would cut a pulse short
  wire cfg_edge = es_en ? sys_wrap : bit_wrap;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_out <= 1'b0;
      act_mf <= 1'b0;
      act_dw <= 1'b0;
    end else if (cfg_edge) begin
      act_out <= ctrl[`CTRL_SYNC_OUT]; // RULE_16
      act_mf <= ctrl[`CTRL_MFRAME]; // RULE_16
      act_dw <= ctrl[`CTRL_DWIDE]; // RULE_16
    end
  end

  // ----------------------------------------
  // Sync pin drive
  // ----------------------------------------
  wire sig_frame = (frame_cnt == `SIG_FRAME_A) |
    (frame_cnt == `SIG_FRAME_B);
  wire line_pulse = act_mf ? frame_wrap : bit_wrap; // RULE_10
  wire wide_tail = t1 & act_dw & ~act_mf & sig_frame & line_fall &
    (bit_cnt == 8'h00); // RULE_11

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_io_out <= 1'b0;
      sync_io_oe_n <= 1'b1;
      sys_pulse <= 1'b0;
    end else begin
      sync_io_oe_n <= ~act_out;
      if (es_en) begin
        // One system period wide, launched on system clock
        if (sys_rise) begin
          sys_pulse <= sys_wrap; // RULE_14
        end
        sync_io_out <= act_out & sys_pulse; // RULE_14
      end else if (line_fall) begin
        sync_io_out <= act_out & (line_pulse | wide_tail); // RULE_12
      end
    end
  end

  // ----------------------------------------
  // Backplane clock and serial data
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      backplane_clock_out <= 1'b0;
      serial_bit <= 1'b0;
      serial_bit_valid <= 1'b0;
    end else begin
      backplane_clock_out <= es_en & sys_lvl; // RULE_14
      serial_bit_valid <= data_edge; // RULE_15
      if (data_edge) begin
        serial_bit <= data_lvl; // RULE_15
      end
    end
  end

  // ----------------------------------------
  // Status pin remap
  // ----------------------------------------
  reg next_status_pin;
  always @* begin
    case (stsel)
      `STSEL_ANALOG: next_status_pin = analog_loss_flag; // RULE_07
      `STSEL_FRAMER: next_status_pin = framer_signal_loss_flag; // RULE_07
      `STSEL_FREEZE: next_status_pin = rx_signaling_freeze_flag; // RULE_07
      default: next_status_pin = 1'b0;
    endcase
  end

  // Port one keeps its pin as the master clock input
  wire remap_on = compat & (PORT_INDEX > 1); // RULE_08
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_pin_out <= 1'b0;
      status_pin_oe_n <= 1'b1;
    end else begin
      status_pin_out <= remap_on & next_status_pin; // RULE_08
      status_pin_oe_n <= ~remap_on; // RULE_08
    end
  end

  // ----------------------------------------
  // Line clock watchdog
  // ----------------------------------------
  localparam [31:0] LOSS_FULL = `LOSS_CYCLES;
  localparam [11:0] LOSS_LIMIT = LOSS_FULL[11:0];
  wire line_edge = line_rise | line_fall;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loss_cnt <= 12'h000;
      clk_loss <= 1'b0;
    end else if (line_edge) begin
      loss_cnt <= 12'h000;
      clk_loss <= 1'b0;
    end else if (loss_cnt == LOSS_LIMIT) begin
      clk_loss <= 1'b1; // RULE_02
    end else begin
      loss_cnt <= loss_cnt + 12'h001;
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  wire [`EV_WIDTH-1:0] events;
  assign events[`EV_FRAME] = bit_wrap;
  assign events[`EV_MFRAME] = frame_wrap;
  assign events[`EV_REALIGN] = line_sync_in | sys_sync_in;
  assign events[`EV_CLKLOSS] = ~clk_loss & ~line_edge &
    (loss_cnt == LOSS_LIMIT);

  wire status_wr = write_strobe & (address == `OFS_STATUS);
  wire [`EV_WIDTH-1:0] clr = status_wr ?
    write_data[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= `EV_RESET;
      irq <= 1'b0;
    end else begin
      // A new event outranks a clear in the same cycle
      status <= (status & ~clr) | events;
      irq <= |(((status & ~clr) | events) & mask);
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
      mask <= `EV_RESET;
    end else if (write_strobe) begin
      case (address)
        `OFS_CTRL: ctrl <= write_data;
        `OFS_MASK: mask <= write_data[`EV_WIDTH-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_data <= 32'h0000_0000;
    end else if (read_strobe) begin
      case (address)
        `OFS_CTRL: read_data <= {22'h00_0000, ctrl[9:8], 1'b0,
          ctrl[6:0]};
        `OFS_STATUS: read_data <= {28'h000_0000, status};
        `OFS_MASK: read_data <= {28'h000_0000, mask};
        `OFS_STATE: read_data <= {20'h0_0000, act_dw, act_mf,
          act_out, clk_loss, 3'h0, frame_cnt};
        default: read_data <= 32'h0000_0000;
      endcase
    end else begin
      read_data <= 32'h0000_0000;
    end
  end
endmodule

/* File: common/tx_sync_regs.vh */
// Register map, field positions, reset values and timing counts
`ifndef TX_SYNC_REGS_VH
`define TX_SYNC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_STATE 8'h0c
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_ES_EN 0
`define CTRL_SYNC_OUT 1
`define CTRL_MFRAME 2
`define CTRL_DWIDE 3
`define CTRL_T1 4
`define CTRL_CLK_INT 5
`define CTRL_COMPAT 6
`define CTRL_STSEL_LO 8
`define CTRL_STSEL_HI 9
`define CTRL_RESET 32'h0000_0000
// ----------------------------------------
// Status and mask fields
// ----------------------------------------
`define EV_FRAME 0
`define EV_MFRAME 1
`define EV_REALIGN 2
`define EV_CLKLOSS 3
`define EV_WIDTH 4
`define EV_RESET 4'h0
// ----------------------------------------
// Status pin selections
// ----------------------------------------
`define STSEL_ANALOG 2'h0
`define STSEL_FRAMER 2'h1
`define STSEL_FREEZE 2'h2
// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define T1_BIT_LIMIT 8'hc0
`define E1_BIT_LIMIT 8'hff
`define T1_FRAME_LIMIT 5'h0b
`define E1_FRAME_LIMIT 5'h0f
`define SIG_FRAME_A 5'h05
`define SIG_FRAME_B 5'h0b
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define LOSS_TIME_NS 640
`define LOSS_CYCLES ((`LOSS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: core/pin_sync.v */
// Two-stage synchroniser with edge detection
`timescale 1ns/1ps
module pin_sync (
  input wire clk,
  input wire rstn,
  input wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg stage1;
  reg stage2;
  reg prev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      prev <= stage2;
    end
  end

  // Edges look only at the second stage onward
  assign level = stage2;
  assign rise = stage2 & ~prev;
  assign fall = ~stage2 & prev;
endmodule

/* File: core/edge_counter.v */
// Wrapping counter stepped by clock-edge enables
`timescale 1ns/1ps
module edge_counter #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rstn,
  input wire step,
  input wire load,
  input wire [WIDTH-1:0] limit,
  output reg [WIDTH-1:0] count,
  output wire wrap
);
  assign wrap = step & (count == limit);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= {WIDTH{1'b0}};
    end else if (step) begin
      if (wrap) begin
        count <= {WIDTH{1'b0}};
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* File: tb/tx_sync_checker_sva.sv */
// Port-level assertions for the transmit sync block
`timescale 1ns/1ps
module tx_sync_checker (
  input wire clk,
  input wire rstn,
  input wire [7:0] address,
  input wire [31:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  input wire [31:0] read_data,
  input wire irq,
  input wire analog_loss_flag,
  input wire framer_signal_loss_flag,
  input wire rx_signaling_freeze_flag,
  input wire status_pin_out,
  input wire status_pin_oe_n,
  input wire backplane_clock_out,
  input wire serial_bit_valid
);
  // ----
  // Shadow of written settings
  // ----
  reg [9:0] ctrl_m;
  reg [3:0] mask_m;
  wire [2:0] flags;
  wire sel_flag;
  assign flags = {rx_signaling_freeze_flag, framer_signal_loss_flag,
    analog_loss_flag};
  // Selection 3 shows nothing
  assign sel_flag = (ctrl_m[9:8] == 2'h3) ? 1'b0 : flags[ctrl_m[9:8]];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_m <= 10'h000;
      mask_m <= 4'h0;
    end else if (write_strobe) begin
      if (address == 8'h00) ctrl_m <= write_data[9:0] & 10'h37f;
      if (address == 8'h08) mask_m <= write_data[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  rd_idle_a:
    assert property (!$past(read_strobe) |-> read_data == 32'h0)
    else $error("read data not zero");
  rd_ctrl_a:
    assert property ($past(read_strobe && address == 8'h00)
      |-> read_data == {22'h0, $past(ctrl_m)})
    else $error("control readback wrong");
  rd_unmap_a:
    assert property ($past(read_strobe && address >= 8'h10)
      |-> read_data == 32'h0)
    else $error("unmapped read not zero");
  irq_mask_a:
    assert property ($past(mask_m) == 4'h0 |-> !irq)
    else $error("interrupt while masked");
  stat_oe_a:
    assert property (status_pin_oe_n == !$past(ctrl_m[6]))
    else $error("status pin enable wrong");
  stat_val_a:
    assert property ($past(ctrl_m[6]) |-> status_pin_out == $past(sel_flag))
    else $error("status pin value wrong");
  bp_off_a:
    assert property (!$past(ctrl_m[0]) && !$past(ctrl_m[0], 2)
      |-> !backplane_clock_out)
    else $error("backplane clock without store");
  valid_one_a:
    assert property (serial_bit_valid |=> !serial_bit_valid)
    else $error("serial valid too long");
  cover property ($rose(status_pin_out));
  cover property ($rose(irq));
  cover property ($rose(backplane_clock_out));
endmodule

/* File: tb/backplane_model.sv */
// Backplane model driving clocks, serial data and the sync pin
`timescale 1ns/1ps
module backplane_model (
  input wire line_run,
  input wire sys_run,
  input wire sync_req,
  input wire sync_on_sys,
  output reg line_clk,
  output reg sys_clk,
  output reg ser_data,
  output wire sync_pin
);
  reg [2:0] cnt;
  reg s_line;
  reg s_sys;
  // ----
  // Clocks and launch
  // ----
  initial begin
    line_clk = 1'b0;
    sys_clk = 1'b0;
    ser_data = 1'b0;
    cnt = 3'h0;
    s_line = 1'b0;
    s_sys = 1'b0;
  end
  // Line clock stops only to provoke a loss
  // No bus mode here, so line clock may run free of system clock
  always #80 if (line_run) line_clk = ~line_clk;
  // 8.192 MHz also suits the bus mode rates
  always #61.035 if (sys_run) sys_clk = ~sys_clk;
  // Launch on rising edges so the falling-edge sample is clean
  always @(posedge line_clk) begin
    cnt <= cnt + 3'h1;
    ser_data <= cnt[0] ^ cnt[2];
    s_line <= sync_req;
  end
  always @(posedge sys_clk) s_sys <= sync_req;
  assign sync_pin = sync_on_sys ? s_sys : s_line;
endmodule

/* File: tb/transmit_sync_clocking_tb_top.sv */
// Testbench top for the transmit sync block
`timescale 1ns/1ps
module transmit_sync_clocking_tb_top;
  reg clk, rstn, write_strobe, read_strobe, line_run, sys_run;
  reg sync_req, sync_on_sys, ser_on;
  reg [7:0] address;
  reg [31:0] write_data, rv;
  reg [2:0] flg;
  wire [31:0] read_data;
  wire irq, sync_io_out, sync_io_oe_n, status_pin_out, status_pin_oe_n;
  wire backplane_clock_out, serial_bit, serial_bit_valid;
  wire line_clk, sys_clk, ser_data, sync_pin, sync_wire;
  integer errors, n_tests, i, k, gap, w, wprev, nw;
  // Pin level: the device wins while it drives
  assign sync_wire = sync_io_oe_n ? sync_pin : sync_io_out;
  backplane_model backplane_model_i (.line_run, .sys_run, .sync_req,
    .sync_on_sys, .line_clk, .sys_clk, .ser_data, .sync_pin);
  transmit_sync_clocking #(
    .PORT_INDEX(2),
    .SYS_CLKS_PER_FRAME(8)
  ) transmit_sync_clocking_i (.clk, .rstn, .address, .write_data,
    .write_strobe, .read_strobe, .read_data, .irq,
    .transmit_line_clock(line_clk), .recovered_rx_clock(sys_clk),
    .transmit_system_clock(sys_clk), .port1_system_clock(line_clk),
    .transmit_serial_data(ser_data), .analog_loss_flag(flg[0]),
    .framer_signal_loss_flag(flg[1]), .rx_signaling_freeze_flag(flg[2]),
    .sync_io_in(sync_wire), .sync_io_out, .sync_io_oe_n, .status_pin_out,
    .status_pin_oe_n, .backplane_clock_out, .serial_bit,
    .serial_bit_valid);
  // ----
  // Tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task print_verdict;
    begin
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: %h vs %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      @(negedge clk);
      rv = read_data;
    end
  endtask
  task wcyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Measures idle gap and width of the next sync pulse in cycles
  task pulse(input integer lim);
    begin
      wprev = w;
      gap = 0;
      w = 0;
      while (sync_io_out !== 1'b1 && gap < lim) begin
        @(negedge clk);
        gap = gap + 1;
      end
      while (sync_io_out === 1'b1 && w < 64) begin
        @(negedge clk);
        w = w + 1;
      end
      if (gap >= lim) begin
        errors = errors + 1;
        print_verdict;
      end
    end
  endtask
  task bpt;
    begin
      k = 0;
      while (backplane_clock_out !== 1'b0 && k < 40) begin
        @(posedge clk);
        k = k + 1;
      end
      while (backplane_clock_out !== 1'b1 && k < 40) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 40) begin
        errors = errors + 1;
        print_verdict;
      end
    end
  endtask
  always @(negedge clk) begin
    if (ser_on && serial_bit_valid === 1'b1) chk(serial_bit, ser_data);
  end
  // ----
  // Sequence
  // ----
  initial begin
    errors = 0;
    n_tests = 0;
    w = 0;
    rstn = 1'b0;
    address = 8'h00;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    flg = 3'h0;
    line_run = 1'b1;
    sys_run = 1'b1;
    sync_req = 1'b0;
    sync_on_sys = 1'b0;
    ser_on = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    chk({irq, sync_io_oe_n, status_pin_oe_n}, 3'h3);
    rd(8'h04);
    chk(rv, 32'h0);
    wr(8'h00, 32'hffff_fffe);
    wr(8'h10, 32'h0);
    rd(8'h00);
    chk(rv, 32'h0000_037e);
    rd(8'h10);
    chk(rv, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h00, 32'h40 | (i << 8));
      flg <= 3'h7 ^ (3'h1 << i);
      wcyc(3);
      chk({status_pin_oe_n, status_pin_out}, 2'h0);
      flg <= 3'h1 << i;
      wcyc(3);
      chk(status_pin_out, i < 3);
    end
    flg <= 3'h7;
    wr(8'h00, 32'h0);
    wcyc(3);
    chk(status_pin_oe_n, 1'b1);
    ser_on <= 1'b1;
    // T1 frames, double-wide at two signaling frames of twelve
    wr(8'h00, 32'h1a);
    pulse(9000);
    pulse(9000);
    nw = 0;
    for (i = 0; i < 12; i = i + 1) begin
      pulse(4000);
      chk(gap + wprev, 3088);
      if (w == 32) nw = nw + 1;
    end
    chk(nw, 2);
    wr(8'h00, 32'h2);
    pulse(9000);
    pulse(4200);
    chk(gap + wprev, 32'h0000_1000);
    chk(w, 32'h0000_0010);
    chk(sync_io_oe_n, 1'b0);
    rd(8'h04);
    chk(rv[1:0], 2'h3);
    // Sync input, multiframe type
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h4);
    wcyc(4200);
    wr(8'h04, 32'hf);
    wcyc(2);
    chk(irq, 1'b0);
    sync_req <= 1'b1;
    wcyc(16);
    sync_req <= 1'b0;
    wcyc(40);
    chk({irq, sync_io_oe_n}, 2'h3);
    rd(8'h0c);
    chk({rv[10], rv[4:0]}, 6'h20);
    wr(8'h08, 32'h0);
    wcyc(2);
    chk(irq, 1'b0);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h4);
    wcyc(2);
    chk(irq, 1'b0);
    // Loss of line clock, then internal source
    line_run <= 1'b0;
    wcyc(100);
    rd(8'h0c);
    chk(rv[8], 1'b1);
    wr(8'h00, 32'h20);
    wcyc(100);
    rd(8'h0c);
    chk(rv[8], 1'b0);
    line_run <= 1'b1;
    ser_on <= 1'b0;
    sync_on_sys <= 1'b1;
    // Store on: system period is 97.66 cycles per 8 clocks
    wr(8'h00, 32'h3);
    pulse(300);
    pulse(300);
    chk(gap + wprev >= 97 && gap + wprev <= 98, 1'b1);
    chk(w >= 12 && w <= 13, 1'b1);
    // Sync input on the system side
    wr(8'h00, 32'h1);
    wcyc(200);
    wr(8'h04, 32'hf);
    wcyc(2);
    chk(irq, 1'b0);
    sync_req <= 1'b1;
    wcyc(13);
    sync_req <= 1'b0;
    wcyc(40);
    chk({irq, sync_io_oe_n}, 2'h3);
    sys_run <= 1'b0;
    wr(8'h00, 32'h43);
    bpt;
    chk(backplane_clock_out, 1'b1);
    wr(8'h00, 32'h0);
    wcyc(3);
    chk(backplane_clock_out, 1'b0);
    print_verdict;
  end
endmodule
bind transmit_sync_clocking tx_sync_checker tx_sync_checker_i (.clk, .rstn,
  .address, .write_data, .write_strobe, .read_strobe, .read_data, .irq,
  .analog_loss_flag, .framer_signal_loss_flag, .rx_signaling_freeze_flag,
  .status_pin_out, .status_pin_oe_n, .backplane_clock_out,
  .serial_bit_valid);
